//--- rtl/flrc_fault_limit_retry.sv
// fault thresholds, over-temperature action register and restart sequencing
`timescale 1ns/1ns
`default_nettype none
`include "flrc_consts.svh"

module flrc_fault_limit_retry #(
  parameter logic [15:0] OC_LV_THR_RST = `FLRC_RST_OC_LV_THR,
  parameter logic [15:0] OC_WARN_THR_RST = `FLRC_RST_OC_WARN_THR,
  parameter logic [15:0] OT_FAULT_THR_RST = `FLRC_RST_OT_FAULT_THR,
  parameter logic [7:0] OT_ACTION_RST = `FLRC_RST_OT_ACTION
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_cmd_ok,
  input wire logic clear_faults,
  input wire logic clear_ot_status,
  input wire logic operation_on,
  input wire logic ctrl_pin_on,
  input wire logic other_fault_shutdown,
  input wire logic delay_unit_tick,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] iout_meas,
  input wire logic [15:0] temp_meas,
  input wire logic oc_limit_active,
  output logic output_enable,
  output logic ot_fault_status,
  output logic oc_warn_status,
  output logic oc_lv_fault_status,
  output logic ot_retrying,
  output logic [2:0] ot_attempts
);

  logic [15:0] oc_lv_thr_q;
  logic [15:0] oc_warn_thr_q;
  logic [15:0] ot_fault_thr_q;
  logic [7:0] ot_action_q;
  logic [15:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic reg_cmd_ok_q;
  logic ctrl_meta_q;
  logic ctrl_sync_q;
  logic ot_status_q;
  logic oc_warn_q;
  logic oc_lv_q;
  logic out_en_q;
  logic ot_retry_q;
  logic [2:0] attempts_q;
  logic [`FLRC_UNIT_CNT_W-1:0] unit_cnt_q;
  logic [`FLRC_UNIT_CNT_W-1:0] unit_load;
  logic was_off_q;
  logic ot_now;
  logic oc_warn_now;
  logic oc_lv_now;
  logic run_cmd;
  logic cleared;
  logic delay_done;
  logic [2:0] retry_code;
  flrc_pkg::flrc_resp_t resp;
  flrc_pkg::flrc_state_t state_q;

  // linear word to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] flrc_lin_fix(input logic [15:0] v);
    logic signed [47:0] mant;
    logic [4:0] sh;
    mant = {{37{v[10]}}, v[10:0]};
    sh = v[15:11] ^ `FLRC_LIN_EXP_BIAS;
    flrc_lin_fix = mant <<< sh;
  endfunction

  // a command code this block owns
  function automatic logic flrc_mapped(input logic [7:0] c);
    flrc_mapped = (c == `FLRC_OFS_OC_LV_THR) || (c == `FLRC_OFS_OC_WARN_THR) ||
                  (c == `FLRC_OFS_OT_FAULT_THR) || (c == `FLRC_OFS_OT_ACTION);
  endfunction

  // threshold and action registers written by the command engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      oc_lv_thr_q <= OC_LV_THR_RST;
      oc_warn_thr_q <= OC_WARN_THR_RST;
      ot_fault_thr_q <= OT_FAULT_THR_RST;
      ot_action_q <= OT_ACTION_RST;
    end
    else if (reg_wr)
    begin
      case (reg_cmd)
        `FLRC_OFS_OC_LV_THR: oc_lv_thr_q <= reg_wdata;
        `FLRC_OFS_OC_WARN_THR: oc_warn_thr_q <= reg_wdata;
        `FLRC_OFS_OT_FAULT_THR: ot_fault_thr_q <= reg_wdata;
        `FLRC_OFS_OT_ACTION: ot_action_q <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // read data registered one cycle after the read strobe; unknown codes read zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata_q <= 16'h0000;
      reg_rvalid_q <= 1'b0;
      reg_cmd_ok_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      reg_cmd_ok_q <= (reg_rd || reg_wr) && flrc_mapped(reg_cmd);
      if (reg_rd)
      begin
        case (reg_cmd)
          `FLRC_OFS_OC_LV_THR: reg_rdata_q <= oc_lv_thr_q;
          `FLRC_OFS_OC_WARN_THR: reg_rdata_q <= oc_warn_thr_q;
          `FLRC_OFS_OT_FAULT_THR: reg_rdata_q <= ot_fault_thr_q;
          `FLRC_OFS_OT_ACTION: reg_rdata_q <= {8'h00, ot_action_q};
          default: reg_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // control pin comes from outside the clock domain
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_meta_q <= 1'b0;
      ctrl_sync_q <= 1'b0;
    end
    else
    begin
      ctrl_meta_q <= ctrl_pin_on;
      ctrl_sync_q <= ctrl_meta_q;
    end
  end

  // comparisons; the low-voltage threshold is unsigned volts with exponent fixed at -10
  always_comb
  begin
    ot_now = flrc_lin_fix(temp_meas) >= flrc_lin_fix(ot_fault_thr_q);
    oc_warn_now = flrc_lin_fix(iout_meas) >= flrc_lin_fix(oc_warn_thr_q);
    oc_lv_now = oc_limit_active && (vout_meas < oc_lv_thr_q);
  end

  assign run_cmd = operation_on && ctrl_sync_q;
  assign resp = flrc_pkg::flrc_resp_t'(ot_action_q[`FLRC_RESP_HI:`FLRC_RESP_LO]);
  assign retry_code = ot_action_q[`FLRC_RETRY_HI:`FLRC_RETRY_LO];
  // one unit is a tick from the unit-time configuration held elsewhere
  assign unit_load = `FLRC_UNIT_CNT_W'(1) << ot_action_q[`FLRC_DELAY_HI:`FLRC_DELAY_LO];
  assign delay_done = delay_unit_tick && (unit_cnt_q == `FLRC_UNIT_CNT_W'(1));

  // off-then-on while latched, a clear command or clearing the status bit releases the latch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      was_off_q <= 1'b0;
    else if (state_q != flrc_pkg::FLRC_ST_LATCHED)
      was_off_q <= 1'b0;
    else if (!run_cmd)
      was_off_q <= 1'b1;
  end

  assign cleared = clear_faults || clear_ot_status || (was_off_q && run_cmd);

  // sticky status: a new fault wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ot_status_q <= 1'b0;
      oc_warn_q <= 1'b0;
      oc_lv_q <= 1'b0;
    end
    else
    begin
      ot_status_q <= ot_now || (ot_status_q && !clear_faults && !clear_ot_status);
      oc_warn_q <= oc_warn_now || (oc_warn_q && !clear_faults);
      oc_lv_q <= oc_lv_now || (oc_lv_q && !clear_faults);
    end
  end

  // delay counter: reloaded at the start of each wait except FLRC_ST_ATTEMPT_OFF, counts down on unit ticks
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      unit_cnt_q <= `FLRC_UNIT_CNT_W'(1);
    else
    begin
      case (state_q)
        flrc_pkg::FLRC_ST_RUN:
          unit_cnt_q <= unit_load;
        flrc_pkg::FLRC_ST_CONTINUE, flrc_pkg::FLRC_ST_OFF_WAIT,
        flrc_pkg::FLRC_ST_ATTEMPT, flrc_pkg::FLRC_ST_ATTEMPT_OFF:
        begin
          if (delay_done)
            unit_cnt_q <= unit_load;
          else if (delay_unit_tick)
            unit_cnt_q <= unit_cnt_q - `FLRC_UNIT_CNT_W'(1);
        end
        default:
          unit_cnt_q <= unit_load;
      endcase
    end
  end

  // restart sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= flrc_pkg::FLRC_ST_OFF;
      attempts_q <= 3'h0;
    end
    // a latched unit ignores other shutdowns; only a clear or an off-then-on cycle releases it
    else if ((other_fault_shutdown || !run_cmd) && state_q != flrc_pkg::FLRC_ST_LATCHED)
    begin
      state_q <= flrc_pkg::FLRC_ST_OFF;
      attempts_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        flrc_pkg::FLRC_ST_OFF:
        begin
          attempts_q <= 3'h0;
          state_q <= flrc_pkg::FLRC_ST_RUN;
        end
        flrc_pkg::FLRC_ST_RUN:
        begin
          attempts_q <= 3'h0;
          if (ot_now)
          begin
            case (resp)
              flrc_pkg::FLRC_RESP_IGNORE:
                state_q <= flrc_pkg::FLRC_ST_RUN;
              flrc_pkg::FLRC_RESP_DELAY_RETRY:
                state_q <= flrc_pkg::FLRC_ST_CONTINUE;
              flrc_pkg::FLRC_RESP_DISABLE_RETRY:
                state_q <= (retry_code == 3'h0) ? flrc_pkg::FLRC_ST_LATCHED
                                                : flrc_pkg::FLRC_ST_OFF_WAIT;
              default:
                state_q <= flrc_pkg::FLRC_ST_LATCHED;
            endcase
          end
        end
        flrc_pkg::FLRC_ST_CONTINUE:
        begin
          // the output stays on through the delay; only a fault still present retries
          if (delay_done)
          begin
            if (!ot_now)
              state_q <= flrc_pkg::FLRC_ST_RUN;
            else if (retry_code == 3'h0)
              state_q <= flrc_pkg::FLRC_ST_LATCHED;
            else
              state_q <= flrc_pkg::FLRC_ST_OFF_WAIT;
          end
        end
        flrc_pkg::FLRC_ST_OFF_WAIT:
        begin
          if (delay_done)
          begin
            attempts_q <= attempts_q + 3'h1;
            state_q <= flrc_pkg::FLRC_ST_ATTEMPT;
          end
        end
        flrc_pkg::FLRC_ST_ATTEMPT:
        begin
          // the spacing counter keeps running after a failed attempt so starts stay one delay apart
          if (ot_now)
            state_q <= flrc_pkg::FLRC_ST_ATTEMPT_OFF;
          else if (delay_done)
            state_q <= flrc_pkg::FLRC_ST_RUN;
        end
        flrc_pkg::FLRC_ST_ATTEMPT_OFF:
        begin
          if (retry_code != 3'h7 && attempts_q >= retry_code)
            state_q <= flrc_pkg::FLRC_ST_LATCHED;
          else if (delay_done)
          begin
            // code 111 never stops and its attempts are not counted against a limit
            if (retry_code != 3'h7)
              attempts_q <= attempts_q + 3'h1;
            state_q <= flrc_pkg::FLRC_ST_ATTEMPT;
          end
        end
        flrc_pkg::FLRC_ST_LATCHED:
        begin
          if (cleared)
          begin
            attempts_q <= 3'h0;
            state_q <= flrc_pkg::FLRC_ST_OFF;
          end
        end
        default:
          state_q <= flrc_pkg::FLRC_ST_OFF;
      endcase
    end
  end

  // output enable registered from the state just entered
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_en_q <= 1'b0;
    else
    begin
      case (state_q)
        flrc_pkg::FLRC_ST_RUN, flrc_pkg::FLRC_ST_CONTINUE, flrc_pkg::FLRC_ST_ATTEMPT:
          out_en_q <= run_cmd && !other_fault_shutdown;
        default:
          out_en_q <= 1'b0;
      endcase
    end
  end

  // retry indication registered so the port comes straight from a flop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ot_retry_q <= 1'b0;
    else
      ot_retry_q <= (state_q == flrc_pkg::FLRC_ST_OFF_WAIT) ||
                    (state_q == flrc_pkg::FLRC_ST_ATTEMPT) ||
                    (state_q == flrc_pkg::FLRC_ST_ATTEMPT_OFF);
  end

  assign reg_rdata = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;
  assign reg_cmd_ok = reg_cmd_ok_q;
  assign output_enable = out_en_q;
  assign ot_fault_status = ot_status_q;
  assign oc_warn_status = oc_warn_q;
  assign oc_lv_fault_status = oc_lv_q;
  assign ot_retrying = ot_retry_q;
  assign ot_attempts = attempts_q;

endmodule
`default_nettype wire

//--- rtl/flrc_consts.svh
// offsets, field positions, reset values and widths of the fault limit and retry block
`ifndef FLRC_CONSTS_SVH
`define FLRC_CONSTS_SVH

`define FLRC_OFS_OC_LV_THR 8'h48
`define FLRC_OFS_OC_WARN_THR 8'h4A
`define FLRC_OFS_OT_FAULT_THR 8'h4F
`define FLRC_OFS_OT_ACTION 8'h50

`define FLRC_RESP_HI 7
`define FLRC_RESP_LO 6
`define FLRC_RETRY_HI 5
`define FLRC_RETRY_LO 3
`define FLRC_DELAY_HI 2
`define FLRC_DELAY_LO 0

`define FLRC_RST_OC_LV_THR 16'h0000
// largest positive linear value, so neither compare trips out of reset
`define FLRC_RST_OC_WARN_THR 16'h7BFF
`define FLRC_RST_OT_FAULT_THR 16'h7BFF
`define FLRC_RST_OT_ACTION 8'h00

`define FLRC_LIN_EXP_BIAS 5'h10
`define FLRC_UNIT_CNT_W 8

`endif

//--- rtl/flrc_pkg.sv
// types shared by the fault limit and retry block
package flrc_pkg;

  typedef enum logic [1:0] {
    FLRC_RESP_IGNORE,
    FLRC_RESP_DELAY_RETRY,
    FLRC_RESP_DISABLE_RETRY,
    FLRC_RESP_LATCH
  } flrc_resp_t;

  typedef enum logic [2:0] {
    FLRC_ST_OFF,
    FLRC_ST_RUN,
    FLRC_ST_CONTINUE,
    FLRC_ST_OFF_WAIT,
    FLRC_ST_ATTEMPT,
    FLRC_ST_ATTEMPT_OFF,
    FLRC_ST_LATCHED
  } flrc_state_t;

endpackage

//--- testbench/flrc_sva.sv
// port-level assertions for the fault limit and retry block
`timescale 1ns/1ns
`default_nettype none
module flrc_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_cmd_ok,
  input wire logic clear_faults,
  input wire logic clear_ot_status,
  input wire logic operation_on,
  input wire logic other_fault_shutdown,
  input wire logic output_enable,
  input wire logic ot_fault_status,
  input wire logic oc_warn_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic mapped;
  wire logic strobe;
  assign mapped = (reg_cmd == 8'h48) || (reg_cmd == 8'h4A) || (reg_cmd == 8'h4F)
    || (reg_cmd == 8'h50);
  assign strobe = reg_wr || reg_rd;

  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("stray read valid");
  map_ok_a: assert property (strobe && mapped |=> reg_cmd_ok)
    else $error("mapped code not acknowledged");
  unmap_ok_a: assert property (!(strobe && mapped) |=> !reg_cmd_ok)
    else $error("unmapped code acknowledged");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  off_cmd_a: assert property ((!operation_on || other_fault_shutdown) |-> ##2 !output_enable)
    else $error("output on while commanded off");
  ot_sticky_a: assert property (ot_fault_status && operation_on && !clear_faults
    && !clear_ot_status |=> ot_fault_status)
    else $error("fault status lost without clear");
  warn_sticky_a: assert property (oc_warn_status && !clear_faults |=> oc_warn_status)
    else $error("warning status lost without clear");
endmodule
bind flrc_fault_limit_retry flrc_sva chk_u (.clk, .rstn, .reg_wr, .reg_rd, .reg_cmd,
  .reg_rdata, .reg_rvalid, .reg_cmd_ok, .clear_faults, .clear_ot_status, .operation_on,
  .other_fault_shutdown, .output_enable, .ot_fault_status, .oc_warn_status);
`default_nettype wire

//--- testbench/flrc_host_model.sv
// command engine model driving the register port of the block
`timescale 1ns/1ns
`default_nettype none
module flrc_host_model (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_cmd_ok,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_cmd,
  output logic [15:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
  end
  // call at a rising edge; lines are scrambled after use so stale data cannot pass
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
    output logic [15:0] q, output logic ok);
    reg_wr <= w;
    reg_rd <= !w;
    reg_cmd <= c;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    reg_cmd <= ~c;
    reg_wdata <= ~d;
    @(posedge clk);
    q = reg_rdata;
    ok = reg_cmd_ok;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the fault limit and retry block
`timescale 1ns/1ns
`default_nettype none
`include "flrc_consts.svh"
module tb_top;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic clear_faults = 1'h0;
  logic clear_ot_status = 1'h0;
  logic operation_on = 1'h0;
  logic ctrl_pin_on = 1'h0;
  logic other_fault_shutdown = 1'h0;
  logic delay_unit_tick = 1'h0;
  logic oc_limit_active = 1'h0;
  logic [15:0] vout_meas = 16'h0000;
  logic [15:0] iout_meas = 16'h0000;
  logic [15:0] temp_meas = 16'h0000;
  logic [15:0] q;
  logic ok;
  wire logic reg_wr, reg_rd, reg_rvalid, reg_cmd_ok, output_enable, ot_retrying;
  wire logic ot_fault_status, oc_warn_status, oc_lv_fault_status;
  wire logic [7:0] reg_cmd;
  wire logic [15:0] reg_wdata, reg_rdata;
  wire logic [2:0] ot_attempts;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  flrc_fault_limit_retry dut_u (.clk, .rstn, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .reg_cmd_ok, .clear_faults, .clear_ot_status, .operation_on,
    .ctrl_pin_on, .other_fault_shutdown, .delay_unit_tick, .vout_meas, .iout_meas,
    .temp_meas, .oc_limit_active, .output_enable, .ot_fault_status, .oc_warn_status,
    .oc_lv_fault_status, .ot_retrying, .ot_attempts);
  flrc_host_model host_u (.clk, .reg_rdata, .reg_cmd_ok, .reg_wr, .reg_rd, .reg_cmd,
    .reg_wdata);

  always #2 clk = ~clk;
  // one delay unit is two clocks, so spacings below are twice the unit count
  always @(posedge clk)
  begin
    delay_unit_tick <= ~delay_unit_tick;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t value got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input logic v, input int n);
    for (int i = 0; i < n && output_enable !== v; i++)
      @(posedge clk);
    chk1(output_enable, v);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(1'h1, c, d, q, ok);
  endtask
  task automatic go(input logic [7:0] act, input logic [15:0] hot);
    temp_meas <= 16'h0010;
    wr(`FLRC_OFS_OT_ACTION, {8'h00, act});
    clear_faults <= 1'h1;
    @(posedge clk);
    clear_faults <= 1'h0;
    operation_on <= 1'h1;
    wt(1'h1, 20);
    temp_meas <= hot;
  endtask

  task automatic t_regs;
    logic [7:0] c [4] = '{8'h48, 8'h4A, 8'h4F, 8'h50};
    logic [15:0] r [4] = '{`FLRC_RST_OC_LV_THR, `FLRC_RST_OC_WARN_THR,
      `FLRC_RST_OT_FAULT_THR, {8'h00, `FLRC_RST_OT_ACTION}};
    for (int i = 0; i < 4; i++)
    begin
      host_u.xfer(1'h0, c[i], 16'h0000, q, ok);
      chk16(q, r[i]);
      chk1(reg_rvalid, 1'h1);
      wr(c[i], 16'hA5C3);
      host_u.xfer(1'h0, c[i], 16'h0000, q, ok);
      chk16(q, (i == 3) ? 16'h00C3 : 16'hA5C3);
      chk1(ok, 1'h1);
    end
    wr(8'h51, 16'h1234);
    chk1(reg_rvalid, 1'h0);
    host_u.xfer(1'h0, 8'h51, 16'h0000, q, ok);
    chk16(q, 16'h0000);
    chk1(ok, 1'h0);
    wr(8'h4F, 16'h0050);
    wr(8'h4A, 16'h0100);
    wr(8'h48, 16'h4800);
  endtask
  task automatic t_oc;
    iout_meas <= 16'h00FF;
    clear_faults <= 1'h1;
    @(posedge clk);
    clear_faults <= 1'h0;
    repeat (3) @(posedge clk);
    chk1(oc_warn_status, 1'h0);
    iout_meas <= 16'h0100;
    repeat (3) @(posedge clk);
    chk1(oc_warn_status, 1'h1);
    oc_limit_active <= 1'h1;
    vout_meas <= 16'h4800;
    repeat (3) @(posedge clk);
    chk1(oc_lv_fault_status, 1'h0);
    vout_meas <= 16'h47FF;
    repeat (3) @(posedge clk);
    chk1(oc_lv_fault_status, 1'h1);
  endtask
  task automatic t_ign;
    go(8'h00, 16'h004F);
    repeat (4) @(posedge clk);
    chk1(ot_fault_status, 1'h0);
    temp_meas <= 16'h0050;
    repeat (4) @(posedge clk);
    chk1(ot_fault_status, 1'h1);
    repeat (20) @(posedge clk);
    chk1(output_enable, 1'h1);
  endtask
  task automatic t_retry(input logic [2:0] n);
    int t0;
    t0 = 0;
    go({2'h2, n, 3'h2}, 16'h0060);
    wt(1'h0, 4);
    for (int k = 1; k <= n; k++)
    begin
      for (int i = 0; i < 40 && ot_attempts !== k[2:0]; i++)
        @(posedge clk);
      if (k > 1)
        chk16(16'(cyc - t0), 16'h0008);
      t0 = cyc;
    end
    repeat (30) @(posedge clk);
    chk16({13'h0000, ot_attempts}, {13'h0000, n});
    chk1(output_enable, 1'h0);
    temp_meas <= 16'h0010;
    clear_ot_status <= 1'h1;
    @(posedge clk);
    clear_ot_status <= 1'h0;
    wt(1'h1, 20);
  endtask
  task automatic t_cont;
    go(8'h43, 16'h0060);
    repeat (13) @(posedge clk);
    chk1(output_enable, 1'h1);
    wt(1'h0, 10);
  endtask
  task automatic t_latch;
    go(8'hFF, 16'h0060);
    wt(1'h0, 6);
    temp_meas <= 16'h0010;
    repeat (20) @(posedge clk);
    chk1(output_enable, 1'h0);
    other_fault_shutdown <= 1'h1;
    @(posedge clk);
    other_fault_shutdown <= 1'h0;
    repeat (6) @(posedge clk);
    chk1(output_enable, 1'h0);
    operation_on <= 1'h0;
    repeat (4) @(posedge clk);
    operation_on <= 1'h1;
    wt(1'h1, 10);
  endtask
  task automatic t_forever;
    go(8'hB8, 16'h0060);
    repeat (100) @(posedge clk);
    chk1(ot_retrying, 1'h1);
    other_fault_shutdown <= 1'h1;
    repeat (4) @(posedge clk);
    chk1(ot_retrying, 1'h0);
    chk1(output_enable, 1'h0);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    ctrl_pin_on <= 1'h1;
    @(posedge clk);
    t_regs();
    t_oc();
    t_ign();
    for (int n = 0; n < 7; n++)
      t_retry(3'(n));
    t_cont();
    t_latch();
    t_forever();
    report_and_stop();
  end
endmodule
`default_nettype wire
